/* logic/computational_unit.sv */
// Behaviour
// RULE1: 17x17 multiply completes in one cycle
// RULE2: Extension bit zero or copy of bit15
// RULE3: Product low feeds ALU same cycle
// RULE4: Product high captured at cycle end
// RULE5: Multiplicand and multiplier source selection
// RULE6: Shift amount decodes to one-hot multiplier
// RULE7: Fraction mode shifts decoded operand once more
// RULE8: Multiplier registers loadable, storable, transferable
// RULE9: Multiplicand latch written from bus, unreadable
// RULE10: Sixteen-bit ALU with multiword strings
// RULE11: First input: zero, bus, high, low, offset
// RULE12: Second input: zero or addressed accumulator
// RULE13: Add, subtract, load, and, or, xor, not
// RULE14: Comparisons never change accumulators
// RULE15: All registers reset to zero
// RULE16: Thirty-two accumulators in two halves
// RULE17: One or two operands, one result written
// RULE18: Four pointers, direct or offset addressing
// RULE19: Accumulator addressing wraps at thirty-one
// RULE20: Two-bit field selects the pointer
// RULE21: Pointers loadable, storable, constant add/load
// RULE22: String working copy increments, pointer kept
// RULE23: Pointer pre-increment or pre-decrement
// RULE24: Swap bit exchanges accumulator and partner
// RULE25: Result may go to offset partner
// RULE26: Product high changes only when told
// RULE27: Offset of sixteen added modulo 32
// RULE28: String carry passes word to word
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module computational_unit
  import cu_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic [REG_AW-1:0]  reg_addr,
  input  wire logic [WORD_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [WORD_W-1:0]  reg_rdata,
  input  wire logic [WORD_W-1:0]  bus_in,
  input  wire logic               mcand_load,
  input  wire logic               mr_const_load,
  input  wire logic               op_valid,
  input  wire alu_op_t            alu_op,
  input  wire a_sel_t             a_sel,
  input  wire b_sel_t             b_sel,
  input  wire logic [1:0]         pointer_select_field,
  input  wire logic               swap_sel,
  input  wire logic               dest_offset,
  input  wire logic               acc_write,
  input  wire premod_t            premod,
  input  wire logic               string_cont,
  input  wire logic               mul_en,
  input  wire mul_src_t           mul_src,
  input  wire mcand_sel_t         mcand_sel,
  input  wire logic               mr_signed,
  input  wire logic               mcand_signed,
  input  wire logic               ph_from_acc,
  input  wire ptr_op_t            ptr_op,
  input  wire logic [ACC_AW-1:0]  ptr_const,
  output logic      [WORD_W-1:0]  alu_result,
  output logic                    carry_flag,
  output logic                    cmp_true
);

  // RULE19: circular pointer arithmetic
  function automatic logic [ACC_AW-1:0] wrap_add(
    input logic [ACC_AW-1:0] a,
    input logic [ACC_AW-1:0] b
  );
    wrap_add = a + b;
  endfunction

  // One-hot shift operand, one place higher in fraction mode
  function automatic logic [EXT_W-1:0] decode_shift(
    input logic [SV_W-1:0] amount,
    input logic            frac
  );
    logic [EXT_W-1:0] one_hot;
    one_hot = {{(EXT_W-1){1'b0}}, 1'b1} << amount;
    decode_shift = frac ? (one_hot << 1) : one_hot;
  endfunction

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  logic [WORD_W-1:0] multiplier_operand_reg;
  logic [WORD_W-1:0] multiplicand_latch_reg;
  logic [WORD_W-1:0] product_high_word_reg;
  logic [SV_W-1:0]   shift_amount_reg;
  logic              fraction_shift_mode_reg;
  logic [ACC_AW-1:0] ptr_reg [PTR_N];
  logic [ACC_AW-1:0] ptr_next [PTR_N];
  logic [ACC_AW-1:0] work_ptr_reg;
  logic [WORD_W-1:0] acc_mem [ACC_N];
  logic              carry_reg;
  logic              equal_reg;

  // Register bus decode
  wire wr_mr   = reg_wr && (reg_addr == OFS_MR);
  wire wr_ph   = reg_wr && (reg_addr == OFS_PH);
  wire wr_sv   = reg_wr && (reg_addr == OFS_SV);
  wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  wire [PTR_N-1:0] wr_ptr = {reg_wr && (reg_addr == OFS_PTR3),
                             reg_wr && (reg_addr == OFS_PTR2),
                             reg_wr && (reg_addr == OFS_PTR1),
                             reg_wr && (reg_addr == OFS_PTR0)};

  // RULE20: pointer field picks pointer
  wire [ACC_AW-1:0] selected_accum_pointer = ptr_reg[pointer_select_field];

  // RULE23: pre-modified pointer value
  wire [ACC_AW-1:0] ptr_premod =
    (premod == PRE_INC) ? wrap_add(selected_accum_pointer, PTR_STEP) :
    // Minus one wraps to all ones in five bits
    (premod == PRE_DEC) ?
      wrap_add(selected_accum_pointer, -PTR_STEP) :
    selected_accum_pointer;

  // RULE22: working copy steps through the string
  wire [ACC_AW-1:0] base_addr =
    string_cont ? wrap_add(work_ptr_reg, PTR_STEP) : ptr_premod;

  // RULE27: partner is sixteen away, modulo 32
  wire [ACC_AW-1:0] partner_addr = wrap_add(base_addr, HALF_OFS);

  // RULE24: swap exchanges the two columns
  wire [ACC_AW-1:0] addr_idx = swap_sel ? partner_addr : base_addr;
  wire [ACC_AW-1:0] offs_idx = swap_sel ? base_addr : partner_addr;
  // RULE25: result may land in the partner
  wire [ACC_AW-1:0] dest_idx = dest_offset ? offs_idx : addr_idx;

  // RULE17: one or two operands from the file
  wire [WORD_W-1:0] acc_out  = acc_mem[addr_idx];
  wire [WORD_W-1:0] offs_out = acc_mem[offs_idx];

  // RULE5: multiplicand source selection
  wire [WORD_W-1:0] mcand_word =
    (mcand_sel == MC_ACC)    ? acc_out  :
    (mcand_sel == MC_OFFSET) ? offs_out : multiplicand_latch_reg;

  // RULE2: extension bit per operand
  wire [EXT_W-1:0] mcand_ext = {mcand_signed & mcand_word[WORD_W-1],
                                mcand_word};
  // RULE6: shift amount decoded to one-hot
  // RULE7: fraction mode adds a place
  wire [EXT_W-1:0] shift_ext = decode_shift(shift_amount_reg,
                                            fraction_shift_mode_reg);
  wire [EXT_W-1:0] mr_ext =
    (mul_src == MUL_SHIFT) ? shift_ext :
    {mr_signed & multiplier_operand_reg[WORD_W-1], multiplier_operand_reg};

  // RULE1: single-cycle signed 17x17 product
  // Decoded shift operand is unsigned: bit 16 set must not read negative
  wire [EXT_W:0] mr_wide =
    (mul_src == MUL_SHIFT) ? {1'b0, shift_ext} : {mr_ext[EXT_W-1], mr_ext};
  wire signed [2*EXT_W:0] product = $signed(mcand_ext) * $signed(mr_wide);
  wire [WORD_W-1:0] product_low_word  = product[WORD_W-1:0];
  wire [WORD_W-1:0] product_high_next = product[2*WORD_W-1:WORD_W];

  // RULE11: first input selection
  // RULE3: product low reaches the ALU
  wire [WORD_W-1:0] alu_first_input =
    (a_sel == A_BUS)    ? bus_in :
    (a_sel == A_PH)     ? product_high_word_reg :
    (a_sel == A_PL)     ? product_low_word :
    (a_sel == A_OFFSET) ? offs_out : RST_WORD;
  // RULE12: second input selection
  wire [WORD_W-1:0] alu_second_input =
    (b_sel == B_ACC) ? acc_out : RST_WORD;

  // RULE28: string carry chains words
  wire is_sub   = (alu_op == OP_SUB);
  wire carry_in = string_cont ? carry_reg : is_sub;
  wire [WORD_W-1:0] a_eff = is_sub ? ~alu_first_input : alu_first_input;
  wire [WORD_W:0] alu_sum = {1'b0, alu_second_input} + {1'b0, a_eff}
                            + {{WORD_W{1'b0}}, carry_in};

  // RULE13: operation select, load is add to zero
  // RULE10: sixteen-bit word per cycle
  wire [WORD_W-1:0] alu_word =
    (alu_op == OP_AND) ? (alu_first_input & alu_second_input) :
    (alu_op == OP_OR)  ? (alu_first_input | alu_second_input) :
    (alu_op == OP_XOR) ? (alu_first_input ^ alu_second_input) :
    (alu_op == OP_NOT) ? ~alu_first_input :
    alu_sum[WORD_W-1:0];

  // Compares fold equality across a whole string
  wire is_cmp     = (alu_op == OP_CMPEQ) || (alu_op == OP_CMPNE);
  wire word_equal = (alu_first_input == alu_second_input);
  wire equal_next = string_cont ? (equal_reg & word_equal) : word_equal;
  wire carry_next = (is_sub || alu_op == OP_ADD) ? alu_sum[WORD_W] : 1'b0;

  // RULE14: compares leave accumulators alone
  wire acc_we = op_valid && acc_write && !is_cmp;
  wire mul_go = op_valid && mul_en;

  // Pointer next values: bus, then constant, then pre-modify
  always_comb begin
    for (int i = 0; i < PTR_N; i++) begin
      ptr_next[i] = ptr_reg[i];
      if (wr_ptr[i]) begin
        ptr_next[i] = reg_wdata[ACC_AW-1:0];
      end else if (op_valid && pointer_select_field == 2'(i)) begin
        if (ptr_op == PTR_ADD) begin
          ptr_next[i] = wrap_add(ptr_reg[i], ptr_const);
        end else if (ptr_op == PTR_LOAD) begin
          ptr_next[i] = ptr_const;
        end else if (!string_cont) begin
          ptr_next[i] = ptr_premod;
        end
      end
    end
  end

  // RULE21: pointer storage
  // RULE18: five-bit pointers, any entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PTR_N; i++) ptr_reg[i] <= RST_PTR;
      work_ptr_reg <= RST_PTR;
    end else begin
      for (int i = 0; i < PTR_N; i++) ptr_reg[i] <= ptr_next[i];
      if (op_valid) work_ptr_reg <= base_addr;
    end
  end

  // RULE16: thirty-two entry accumulator file
  // RULE15: everything clears on reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ACC_N; i++) acc_mem[i] <= RST_WORD;
    end else if (acc_we) begin
      acc_mem[dest_idx] <= alu_word;
    end
  end

  // RULE4: high half latched at cycle end
  // RULE26: otherwise product high holds
  // RULE8: loads from register port and accumulators
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      product_high_word_reg <= RST_WORD;
    end else if (wr_ph) begin
      product_high_word_reg <= reg_wdata;
    end else if (mul_go) begin
      product_high_word_reg <= product_high_next;
    end else if (ph_from_acc) begin
      product_high_word_reg <= acc_out;
    end
  end

  // RULE8: multiplier register and constants
  // RULE9: latch loads only from data bus
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_operand_reg  <= RST_WORD;
      multiplicand_latch_reg  <= RST_WORD;
      shift_amount_reg        <= RST_SV;
      fraction_shift_mode_reg <= 1'b0;
    end else begin
      if (wr_mr) multiplier_operand_reg <= reg_wdata;
      else if (mr_const_load) multiplier_operand_reg <= bus_in;
      if (mcand_load) multiplicand_latch_reg <= bus_in;
      if (wr_sv) shift_amount_reg <= reg_wdata[SV_W-1:0];
      if (wr_ctrl) fraction_shift_mode_reg <= reg_wdata[CTRL_FRAC_BIT];
    end
  end

  // Result and flags, held between operations
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alu_result <= RST_WORD;
      carry_reg  <= 1'b0;
      equal_reg  <= 1'b0;
      cmp_true   <= 1'b0;
    end else if (op_valid) begin
      alu_result <= alu_word;
      carry_reg  <= carry_next;
      equal_reg  <= equal_next;
      cmp_true   <= (alu_op == OP_CMPNE) ? !equal_next : equal_next;
    end
  end
  assign carry_flag = carry_reg;

  // Read mux; the multiplicand latch has no read path by design
  wire [WORD_W-1:0] stat_word =
    RST_WORD | (WORD_W'(carry_reg) << STAT_CARRY_BIT)
             | (WORD_W'(equal_reg) << STAT_EQ_BIT);
  wire [WORD_W-1:0] read_word =
    (reg_addr == OFS_MR)   ? multiplier_operand_reg :
    (reg_addr == OFS_PH)   ? product_high_word_reg :
    (reg_addr == OFS_SV)   ? WORD_W'(shift_amount_reg) :
    (reg_addr == OFS_CTRL) ? WORD_W'(fraction_shift_mode_reg) :
    (reg_addr == OFS_PTR0) ? WORD_W'(ptr_reg[0]) :
    (reg_addr == OFS_PTR1) ? WORD_W'(ptr_reg[1]) :
    (reg_addr == OFS_PTR2) ? WORD_W'(ptr_reg[2]) :
    (reg_addr == OFS_PTR3) ? WORD_W'(ptr_reg[3]) :
    (reg_addr == OFS_STAT) ? stat_word : RST_WORD;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) reg_rdata <= RST_WORD;
    else if (reg_rd) reg_rdata <= read_word;
    else reg_rdata <= RST_WORD;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Product high follows the multiply
  a_ph_capture: assert property (mul_go && !wr_ph |=> // RULE4
    product_high_word_reg == $past(product_high_next))
    else $error("product high not captured");

  a_ph_hold: assert property (!mul_go && !wr_ph && !ph_from_acc // RULE26
    |=> $stable(product_high_word_reg))
    else $error("product high changed without cause");

  a_shift_decode: assert property (mul_go && mul_src == MUL_SHIFT // RULE6
    && !fraction_shift_mode_reg |->
    product[2*WORD_W-1:0] ==
      ({{WORD_W{mcand_signed & mcand_word[WORD_W-1]}}, mcand_word}
       << shift_amount_reg))
    else $error("barrel shift result wrong");

  a_frac_shift: assert property (mul_go && mul_src == MUL_SHIFT // RULE7
    && fraction_shift_mode_reg |->
    product[2*WORD_W:0] ==
      (({{(WORD_W+1){mcand_signed & mcand_word[WORD_W-1]}}, mcand_word}
        << shift_amount_reg) << 1))
    else $error("fraction shift result wrong");

  a_unsigned_ext: assert property (mul_go && mul_src == MUL_MR // RULE2
    && !mr_signed && !mcand_signed |-> !product[2*EXT_W])
    else $error("unsigned product negative");

  a_cmp_keep: assert property (op_valid && is_cmp // RULE14
    |=> acc_mem[$past(dest_idx)] == $past(acc_mem[dest_idx]))
    else $error("compare changed accumulator");

  a_acc_store: assert property (acc_we |=> // RULE17
    acc_mem[$past(dest_idx)] == $past(alu_word))
    else $error("accumulator write lost");

  a_load_zero: assert property (op_valid && alu_op == OP_ADD // RULE13
    && a_sel == A_BUS && b_sel == B_ZERO && !string_cont
    |=> alu_result == $past(bus_in))
    else $error("load did not pass bus value");

  a_string_ptr: assert property (op_valid && string_cont // RULE22
    && ptr_op == PTR_NONE && wr_ptr == 4'h0 |=>
    ptr_reg[$past(pointer_select_field)] == $past(selected_accum_pointer))
    else $error("string changed stored pointer");

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == RST_WORD)
    else $error("read data outside read cycle");

  c_multiply: cover property (mul_go && mul_src == MUL_MR && acc_we);
  c_string: cover property (op_valid ##1 op_valid && string_cont);
  c_compare: cover property (op_valid && alu_op == OP_CMPEQ && cmp_true);
  c_swap: cover property (acc_we && swap_sel && dest_offset);

endmodule
`default_nettype wire

/* logic/cu_pkg.sv */
`default_nettype none
package cu_pkg;

  // Datapath sizes
  localparam int WORD_W   = 16;
  localparam int EXT_W    = 17;
  localparam int ACC_AW   = 5;
  localparam int ACC_N    = 32;
  localparam int PTR_N    = 4;
  localparam int SV_W     = 4;
  localparam int REG_AW   = 8;
  localparam logic [ACC_AW-1:0] HALF_OFS = 5'h10;
  localparam logic [ACC_AW-1:0] PTR_STEP = 5'h01;

  // Register map, byte offsets of aligned words
  localparam logic [REG_AW-1:0] OFS_MR   = 8'h00;
  localparam logic [REG_AW-1:0] OFS_PH   = 8'h04;
  localparam logic [REG_AW-1:0] OFS_SV   = 8'h08;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_PTR0 = 8'h10;
  localparam logic [REG_AW-1:0] OFS_PTR1 = 8'h14;
  localparam logic [REG_AW-1:0] OFS_PTR2 = 8'h18;
  localparam logic [REG_AW-1:0] OFS_PTR3 = 8'h1c;
  localparam logic [REG_AW-1:0] OFS_STAT = 8'h20;

  // Field positions
  localparam int CTRL_FRAC_BIT = 0;
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_EQ_BIT    = 1;

  // Reset values
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [ACC_AW-1:0] RST_PTR  = 5'h00;
  localparam logic [SV_W-1:0]   RST_SV   = 4'h0;

  typedef enum logic [2:0] {
    A_ZERO = 3'h0, A_BUS = 3'h1, A_PH = 3'h2, A_PL = 3'h3, A_OFFSET = 3'h4
  } a_sel_t;
  typedef enum logic {B_ZERO = 1'h0, B_ACC = 1'h1} b_sel_t;
  typedef enum logic [2:0] {
    OP_ADD = 3'h0, OP_SUB = 3'h1, OP_AND = 3'h2, OP_OR = 3'h3,
    OP_XOR = 3'h4, OP_NOT = 3'h5, OP_CMPEQ = 3'h6, OP_CMPNE = 3'h7
  } alu_op_t;
  typedef enum logic [1:0] {
    MC_LATCH = 2'h0, MC_ACC = 2'h1, MC_OFFSET = 2'h2
  } mcand_sel_t;
  typedef enum logic {MUL_MR = 1'h0, MUL_SHIFT = 1'h1} mul_src_t;
  typedef enum logic [1:0] {
    PTR_NONE = 2'h0, PTR_ADD = 2'h1, PTR_LOAD = 2'h2
  } ptr_op_t;
  typedef enum logic [1:0] {
    PRE_NONE = 2'h0, PRE_INC = 2'h1, PRE_DEC = 2'h2
  } premod_t;

endpackage
`default_nettype wire

/* tb/bus_source.sv */
`timescale 1ns/100ps
`default_nettype none
// Stand-in for memory and constant sources on the internal data bus
module bus_source (
  input  wire logic        clock,
  input  wire logic        drive,
  input  wire logic [15:0] word,
  output logic      [15:0] bus_word
);
  logic [15:0] last_reg;

  // Remember the last driven word
  always_ff @(posedge clock) begin
    if (drive) last_reg <= word;
  end

  // Released bus shows inverted old data, so a stale read cannot pass
  assign bus_word = drive ? word : ~last_reg;
endmodule
`default_nettype wire

/* tb/computational_unit_test.sv */
`timescale 1ns/100ps
`default_nettype none
module computational_unit_test
  import cu_pkg::*;
;
  logic        clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        mcand_load = 1'b0, mr_const_load = 1'b0, op_valid = 1'b0;
  logic        swap_sel = 1'b0, dest_offset = 1'b0, acc_write = 1'b0;
  logic        string_cont = 1'b0, mul_en = 1'b0, mr_signed = 1'b0;
  logic        mcand_signed = 1'b0, ph_from_acc = 1'b0, drive = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, word = 16'h0000;
  logic [1:0]  pointer_select_field = 2'h0;
  logic [4:0]  ptr_const = 5'h01;
  alu_op_t     alu_op = OP_ADD;
  a_sel_t      a_sel = A_ZERO;
  b_sel_t      b_sel = B_ZERO;
  premod_t     premod = PRE_NONE;
  mul_src_t    mul_src = MUL_MR;
  mcand_sel_t  mcand_sel = MC_LATCH;
  ptr_op_t     ptr_op = PTR_NONE;
  logic [15:0] bus_in, reg_rdata, alu_result, x, y, ph;
  logic        carry_flag, cmp_true;
  int          failures = 0, checked = 0, seed = 32'he2b7, i, r;
  int          acc[32];
  bit          at_edge = 1'b0;
  longint      p;

  computational_unit i_dut (.clock, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .bus_in, .mcand_load, .mr_const_load,
    .op_valid, .alu_op, .a_sel, .b_sel, .pointer_select_field, .swap_sel,
    .dest_offset, .acc_write, .premod, .string_cont, .mul_en, .mul_src,
    .mcand_sel, .mr_signed, .mcand_signed, .ph_from_acc, .ptr_op,
    .ptr_const, .alu_result, .carry_flag, .cmp_true);
  bus_source i_bus (.clock, .drive, .word, .bus_word(bus_in));

  // 250 MHz clock
  always #2 clock = ~clock;

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, e);
  endtask

  // Reference ALU; bit 16 holds carry or no-borrow
  function automatic int alu_ref(int o, int a, int b);
    case (o)
      0: return b + a;
      1: return b + (a ^ 16'hffff) + 1;
      2: return a & b;
      3: return a | b;
      4: return a ^ b;
      default: return a ^ 16'hffff;
    endcase
  endfunction

  // One operation word; keep leaves it up for a following string word
  task automatic op(a_sel_t as, b_sel_t bs, alu_op_t o, bit w,
    logic [1:0] ps, logic [15:0] bw, bit m = 0, mul_src_t ms = MUL_MR,
    bit ml = 0, bit mk = 0, bit pa = 0, ptr_op_t po = PTR_NONE,
    premod_t pm = PRE_NONE, bit sc = 0, bit dof = 0, bit sw = 0,
    bit keep = 0, mcand_sel_t mc = MC_LATCH, logic [4:0] pk = 5'h01);
    if (!at_edge) @(posedge clock);
    a_sel <= as;
    b_sel <= bs;
    alu_op <= o;
    acc_write <= w;
    pointer_select_field <= ps;
    word <= bw;
    drive <= 1'b1;
    mul_en <= m;
    mul_src <= ms;
    mcand_load <= ml;
    mr_const_load <= mk;
    ph_from_acc <= pa;
    ptr_op <= po;
    premod <= pm;
    string_cont <= sc;
    dest_offset <= dof;
    swap_sel <= sw;
    mcand_sel <= mc;
    ptr_const <= pk;
    op_valid <= ~(ml | mk);
    @(posedge clock);
    at_edge = keep;
    if (!keep) begin
      op_valid <= 1'b0;
      mul_en <= 1'b0;
      mcand_load <= 1'b0;
      mr_const_load <= 1'b0;
      ph_from_acc <= 1'b0;
      drive <= 1'b0;
      #1;
    end
  endtask

  task automatic peek(logic [1:0] ps, int e);
    op(A_ZERO, B_ACC, OP_ADD, 1'b0, ps, 16'h0000);
    chk("acc", alu_result, 16'(e));
  endtask

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #400000;
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Reset state of every offset, one unmapped
    for (i = 0; i < 10; i++) rd(8'(4 * i), 16'h0000);
    peek(2'h0, 0);
    // Register access, short constant to multiplier
    x = $random(seed);
    y = $random(seed);
    wr(OFS_MR, x);
    rd(OFS_MR, x);
    wr(OFS_SV, x);
    rd(OFS_SV, {12'h000, x[3:0]});
    wr(8'h24, x);
    rd(8'h24, 16'h0000);
    op(A_ZERO, B_ZERO, OP_ADD, 1'b0, 2'h0, y, .mk(1'b1));
    rd(OFS_MR, y);
    for (i = 0; i < 4; i++) begin
      wr(OFS_PTR0 + 8'(4 * i), 16'(4 * i + 3));
      rd(OFS_PTR0 + 8'(4 * i), 16'(4 * i + 3));
    end
    // Four sign combinations, then accumulate on odd passes
    for (i = 0; i < 4; i++) begin
      x = $random(seed);
      y = $random(seed);
      wr(OFS_MR, x);
      op(A_ZERO, B_ZERO, OP_ADD, 1'b0, 2'h0, y, .ml(1'b1));
      @(posedge clock);
      mr_signed <= i[0];
      mcand_signed <= i[1];
      p = (i[1] ? longint'($signed(y)) : longint'(y))
        * (i[0] ? longint'($signed(x)) : longint'(x));
      r = (i[0] ? acc[3] : 0) + int'(p[15:0]);
      op(A_PL, b_sel_t'(i[0]), OP_ADD, 1'b1, 2'h0, 16'h0000, .m(1'b1));
      acc[3] = r & 65535;
      chk("low", alu_result, 16'(r));
      rd(OFS_PH, p[31:16]);
      peek(2'h0, acc[3]);
    end
    // Shift decode, plain then fractional
    @(posedge clock);
    mr_signed <= 1'b0;
    mcand_signed <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 16'(i != 0));
      wr(OFS_SV, (i == 1) ? 16'h0007 : 16'h000f);
      p = longint'(y) << ((i == 0) ? 15 : (i == 1) ? 8 : 16);
      op(A_PL, B_ZERO, OP_ADD, 1'b0, 2'h0, 16'h0000, .m(1'b1),
        .ms(MUL_SHIFT));
      chk("shift", alu_result, p[15:0]);
      rd(OFS_PH, p[31:16]);
    end
    ph = p[31:16];
    wr(OFS_CTRL, 16'h0000);
    // Every arithmetic and logic code against the model
    for (i = 0; i < 6; i++) begin
      x = $random(seed);
      r = alu_ref(i, x, acc[3]);
      op(A_BUS, B_ACC, alu_op_t'(i), 1'b1, 2'h0, x);
      acc[3] = r & 65535;
      chk("alu", alu_result, 16'(r));
      chk("carry", 16'(carry_flag), 16'(r >> 16));
    end
    // Compares with write asked for must not touch the entry
    for (i = 0; i < 4; i++) begin
      op(A_BUS, B_ACC, alu_op_t'(6 + i[0]), 1'b1, 2'h0,
        i[1] ? ~16'(acc[3]) : 16'(acc[3]));
      chk("cmp", 16'(cmp_true), 16'(i[0] ^ !i[1]));
      peek(2'h0, acc[3]);
    end
    // Product high held through ALU work, then loaded from accumulator
    op(A_PH, B_ZERO, OP_ADD, 1'b0, 2'h0, 16'h0000);
    chk("ph", alu_result, ph);
    op(A_ZERO, B_ZERO, OP_ADD, 1'b0, 2'h0, 16'h0000, .pa(1'b1));
    rd(OFS_PH, 16'(acc[3]));
    // Partner entries: result steering, swap and wrap
    x = $random(seed);
    op(A_BUS, B_ZERO, OP_ADD, 1'b1, 2'h0, x, .dof(1'b1));
    op(A_OFFSET, B_ZERO, OP_ADD, 1'b0, 2'h0, 16'h0000);
    chk("offset", alu_result, x);
    op(A_ZERO, B_ACC, OP_ADD, 1'b0, 2'h0, 16'h0000, .sw(1'b1));
    chk("swap", alu_result, x);
    wr(OFS_PTR2, 16'h0013);
    op(A_OFFSET, B_ACC, OP_ADD, 1'b0, 2'h2, 16'h0000);
    chk("wrap", alu_result, 16'(acc[3]) + x);
    // Multiplicand from the addressed entry, then from its partner
    wr(OFS_MR, 16'h0001);
    for (i = 1; i < 3; i++) begin
      op(A_PL, B_ZERO, OP_ADD, 1'b0, 2'h0, 16'h0000, .m(1'b1),
        .mc(mcand_sel_t'(i)));
      chk("mcand", alu_result, (i == 1) ? 16'(acc[3]) : x);
    end
    // Pointer constant add, load and pre-decrement, random constant
    x = $random(seed);
    wr(OFS_PTR3, 16'h001f);
    op(A_ZERO, B_ZERO, OP_ADD, 1'b0, 2'h3, 16'h0000, .po(PTR_ADD),
      .pk(x[4:0]));
    rd(OFS_PTR3, {11'h000, x[4:0] + 5'h1f});
    op(A_ZERO, B_ZERO, OP_ADD, 1'b0, 2'h3, 16'h0000, .po(PTR_LOAD),
      .pk(~x[4:0]));
    rd(OFS_PTR3, {11'h000, ~x[4:0]});
    wr(OFS_PTR3, 16'h0004);
    op(A_ZERO, B_ACC, OP_ADD, 1'b0, 2'h3, 16'h0000, .pm(PRE_DEC));
    chk("pre", alu_result, 16'(acc[3]));
    rd(OFS_PTR3, 16'h0003);
    wr(OFS_PTR3, 16'h0002);
    op(A_ZERO, B_ACC, OP_ADD, 1'b0, 2'h3, 16'h0000, .pm(PRE_INC));
    chk("inc", alu_result, 16'(acc[3]));
    rd(OFS_PTR3, 16'h0003);
    // Two-word string add across entry 31, carry chained
    wr(OFS_PTR3, 16'h001f);
    op(A_BUS, B_ZERO, OP_ADD, 1'b1, 2'h3, 16'hffff);
    op(A_BUS, B_ACC, OP_ADD, 1'b1, 2'h3, 16'h0001, .keep(1'b1));
    op(A_BUS, B_ACC, OP_ADD, 1'b1, 2'h3, 16'h0005, .sc(1'b1));
    chk("string", alu_result, 16'h0006);
    rd(OFS_PTR3, 16'h001f);
    peek(2'h3, 0);
    // Reset again mid-run: state from the string work must clear
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFS_PH, 16'h0000);
    rd(OFS_PTR3, 16'h0000);
    peek(2'h0, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
